/* hw/dual_adc_conversion_sequencer.sv */
// conversion sequencer for a dual simultaneous-sampling converter pair
// assumes the external conversion clock and all strobes are already
// synchronous to clk_sys_in; the host samples busy and reads the fifo
`timescale 1ns/1ps
`include "adc_seq_regs.svh"

// Summary of operation
// - two converters sample and convert together
// - conversion spans thirteen external clock periods
// - busy rises after trigger fall, except nap
// - busy falls after fourteenth rising clock edge
// - trigger fall starts on next rising edge
// - per-converter multiplexer follows two-bit code
// - differential mode codes 00 and 11
// - pseudo mode uses pair-zero negative common, except code 11
// - ten-bit dac register sets reference output
// - pseudo codes 01 and 10 route pair one
// - strobes ignored unless select is low
// - busy high only from hold to done
module dual_adc_conversion_sequencer
   import adc_seq_pkg::*;
(
   // clock and reset
   input wire logic clk_sys_in,
   input wire logic rst_in,
   // conversion control from the host
   input wire logic sample_hold_trigger_n_in,
   input wire logic ext_clock_in,
   input wire logic auto_nap_in,
   // parallel strobes
   input wire logic select_n_in,
   input wire logic read_n_in,
   input wire logic write_n_in,
   input wire logic [`SAMPLE_BITS-1:0] write_data_in,
   input wire logic write_is_dac_in,
   // results of the two analog converters and pseudo mode select
   input wire logic [`SAMPLE_BITS-1:0] conv_a_result_in,
   input wire logic [`SAMPLE_BITS-1:0] conv_b_result_in,
   input wire logic pseudo_mode_in,
   // status and routing outputs
   output logic busy_out,
   output logic hold_out,
   output logic [3:0] conv_step_out,
   output mux_route_type route_out,
   output logic [`REF_DAC_BITS-1:0] reference_output_out,
   output logic [1:0] input_code_out,
   // result stream to the host
   output logic [`SAMPLE_BITS-1:0] read_data_out,
   output logic read_valid_out,
   output logic overflow_out
);
   // ------------------------------------------------------------
   // edge detection and state
   // ------------------------------------------------------------
   seq_state_type state; // sequencer state
   logic trig_q; // previous trigger level
   logic clk_q; // previous external clock level
   logic rd_q; // previous read strobe
   logic wr_q; // previous write strobe
   logic [3:0] edge_cnt; // rising edges since start
   logic trig_fall;
   logic clk_rise;
   logic rd_fall;
   logic wr_rise;
   logic store_valid; // result pair waiting to enter fifo
   sample_pair_type store_word; // captured pair
   logic fifo_ready;
   logic fifo_valid;
   sample_pair_type fifo_word;
   logic half_sel; // which converter the next read returns
   logic input_code_hi; // upper channel code bit
   logic input_code_lo; // lower channel code bit

   assign trig_fall = trig_q & ~sample_hold_trigger_n_in;
   assign clk_rise = ~clk_q & ext_clock_in;
   // select gates both strobes; high select ignores them
   assign rd_fall = rd_q & ~read_n_in & ~select_n_in;
   assign wr_rise = ~wr_q & write_n_in & ~select_n_in;

   // routing decode, used for both converters
   function automatic mux_route_type route_of(input logic pseudo,
                                              input logic [1:0] code);
      mux_route_type r;
      r.pos = src_none;
      r.neg = src_none;
      if (pseudo) begin
         // pair-zero negative is the common reference
         r.neg = src_pair_zero_neg_common;
         case (code)
            2'h0: r.pos = src_pair_zero_pos;
            2'h1: r.pos = src_pair_one_neg;
            2'h2: r.pos = src_pair_one_pos;
            default: begin
               r.pos = src_none;
               r.neg = src_none;
            end
         endcase
      end else begin
         case (code)
            2'h0: begin
               r.pos = src_pair_zero_pos;
               r.neg = src_pair_zero_neg_common;
            end
            2'h3: begin
               r.pos = src_pair_one_pos;
               r.neg = src_pair_one_neg;
            end
            default: begin
               r.pos = src_none;
            end
         endcase
      end
      return r;
   endfunction

   // ------------------------------------------------------------
   // input history registers
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         trig_q <= 1'b1;
         clk_q <= 1'b0;
         rd_q <= 1'b1;
         wr_q <= 1'b1;
      end else begin
         trig_q <= sample_hold_trigger_n_in;
         clk_q <= ext_clock_in;
         rd_q <= read_n_in;
         wr_q <= write_n_in;
      end
   end

   // ------------------------------------------------------------
   // conversion sequencer
   // ------------------------------------------------------------
   // trigger fall enters hold at once; the first rising edge after it
   // is the start edge, counted as one
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         state <= st_idle;
         edge_cnt <= 4'h0;
      end else begin
         case (state)
            st_idle: begin
               // a trigger while busy is ignored, not restarted
               if (trig_fall) begin
                  state <= clk_rise ? st_conv : st_wait;
                  edge_cnt <= clk_rise ? 4'h1 : 4'h0;
               end
            end
            st_wait: begin
               if (clk_rise) begin
                  state <= st_conv;
                  edge_cnt <= 4'h1;
               end
            end
            st_conv: begin
               if (clk_rise) begin
                  edge_cnt <= 4'(edge_cnt + 1'b1);
                  if (edge_cnt == 4'(`BUSY_END_EDGE - 1)) begin
                     state <= st_idle;
                  end
               end
            end
            default: begin
               state <= st_idle;
               edge_cnt <= 4'h0;
            end
         endcase
      end
   end

   // busy frames the hold; suppressed in nap mode
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         busy_out <= 1'b0;
      end else begin
         busy_out <= (state != st_idle || trig_fall) && !auto_nap_in;
      end
   end

   assign hold_out = (state != st_idle); // both converters hold
   assign conv_step_out = edge_cnt;

   // ------------------------------------------------------------
   // result capture: both converters stored as one pair
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         store_valid <= 1'b0;
         store_word <= '0;
         overflow_out <= 1'b0;
      end else begin
         if (state == st_conv && clk_rise &&
             edge_cnt == 4'(`BUSY_END_EDGE - 1)) begin
            store_word.conv_a <= conv_a_result_in;
            store_word.conv_b <= conv_b_result_in;
            store_valid <= 1'b1;
            overflow_out <= store_valid; // pair dropped by back-pressure
         end else if (fifo_ready) begin
            store_valid <= 1'b0;
         end
      end
   end

   sample_fifo #(
      .width($bits(sample_pair_type)),
      .depth(`FIFO_DEPTH)
   ) result_fifo (
      .clk_sys_in(clk_sys_in),
      .rst_in(rst_in),
      .in_valid_in(store_valid),
      .in_ready_out(fifo_ready),
      .in_data_in(store_word),
      .out_valid_out(fifo_valid),
      .out_ready_in(rd_fall && half_sel),
      .out_data_out(fifo_word)
   );

   // ------------------------------------------------------------
   // read port: converter a then b on successive read falls
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         half_sel <= 1'b0;
         read_data_out <= '0;
         read_valid_out <= 1'b0;
      end else begin
         read_valid_out <= rd_fall && fifo_valid;
         if (rd_fall && fifo_valid) begin
            read_data_out <= half_sel ? fifo_word.conv_b : fifo_word.conv_a;
            half_sel <= ~half_sel;
         end
      end
   end

   // ------------------------------------------------------------
   // write port: channel code and reference dac
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         input_code_hi <= 1'(`INPUT_CODE_RESET >> 1);
         input_code_lo <= 1'(`INPUT_CODE_RESET);
         reference_output_out <= `REF_DAC_RESET;
      end else if (wr_rise) begin
         if (write_is_dac_in) begin
            reference_output_out <= write_data_in[`REF_DAC_BITS-1:0];
         end else begin
            input_code_hi <= write_data_in[1];
            input_code_lo <= write_data_in[0];
         end
      end
   end

   assign input_code_out = {input_code_hi, input_code_lo};
   assign route_out = route_of(pseudo_mode_in, input_code_out);

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   busy_rise_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      (state == st_idle && trig_fall && !auto_nap_in) |=> busy_out)
      else $error("busy did not rise after trigger");
   busy_fall_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      (state == st_conv && clk_rise && edge_cnt == 4'hd)
      |=> state == st_idle ##1 !busy_out)
      else $error("busy did not fall after last edge");
   start_edge_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      (state == st_wait && clk_rise) |=> edge_cnt == 4'h1)
      else $error("conversion start edge wrong");
   step_count_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      (state == st_conv && clk_rise && edge_cnt < 4'hd)
      |=> edge_cnt == $past(edge_cnt) + 4'h1)
      else $error("conversion step count wrong");
   busy_frame_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      (!auto_nap_in && $past(!auto_nap_in) && $past(state) == st_conv)
      |-> busy_out)
      else $error("busy low during conversion");
   select_gate_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      select_n_in |=> $stable(reference_output_out))
      else $error("write taken while deselected");
   pseudo_ref_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      (pseudo_mode_in && input_code_out != 2'h3)
      |-> route_out.neg == src_pair_zero_neg_common)
      else $error("pseudo mode lost common reference");
   diff_one_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      (!pseudo_mode_in && input_code_out == 2'h3)
      |-> route_out.pos == src_pair_one_pos &&
          route_out.neg == src_pair_one_neg)
      else $error("differential pair one route wrong");
endmodule

/* hw/sample_fifo.sv */
// flip-flop fifo with valid/ready on both sides
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ps
module sample_fifo #(
   parameter int width = 24,
   parameter int depth = 32
) (
   // clock and reset
   input wire logic clk_sys_in,
   input wire logic rst_in,
   // fill side
   input wire logic in_valid_in,
   output logic in_ready_out,
   input wire logic [width-1:0] in_data_in,
   // drain side
   output logic out_valid_out,
   input wire logic out_ready_in,
   output logic [width-1:0] out_data_out
);
   localparam int aw = $clog2(depth);
   logic [width-1:0] mem [depth]; // storage words
   logic [aw-1:0] wr_ptr; // next write slot
   logic [aw-1:0] rd_ptr; // next read slot
   logic [aw:0] count; // words held
   logic push;
   logic pop;

   assign in_ready_out = (count != (aw+1)'(depth));
   assign out_valid_out = (count != '0);
   assign out_data_out = mem[rd_ptr];
   assign push = in_valid_in & in_ready_out;
   assign pop = out_valid_out & out_ready_in;

   // write storage
   always_ff @(posedge clk_sys_in) begin
      if (push) begin
         mem[wr_ptr] <= in_data_in;
      end
   end

   // pointers and fill level
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else begin
         if (push) begin
            wr_ptr <= aw'(wr_ptr + 1'b1);
         end
         if (pop) begin
            rd_ptr <= aw'(rd_ptr + 1'b1);
         end
         count <= (aw+1)'(count + push - pop);
      end
   end
endmodule

/* include/adc_seq_pkg.sv */
// types shared by the conversion sequencer and its bench
// assumes adc_seq_regs.svh is on the include path
`include "adc_seq_regs.svh"
package adc_seq_pkg;
   // sequencer states
   typedef enum logic [1:0] {
      st_idle = 2'b00,
      st_wait = 2'b01,
      st_conv = 2'b10
   } seq_state_type;

   // multiplexer routing code for one converter's positive/negative side
   typedef enum logic [2:0] {
      src_none = 3'b000,
      src_pair_zero_pos = 3'b001,
      src_pair_zero_neg_common = 3'b010,
      src_pair_one_pos = 3'b011,
      src_pair_one_neg = 3'b100
   } mux_src_type;

   // routing selected for one converter
   typedef struct packed {
      mux_src_type pos;
      mux_src_type neg;
   } mux_route_type;

   // one simultaneous result pair
   typedef struct packed {
      logic [`SAMPLE_BITS-1:0] conv_a;
      logic [`SAMPLE_BITS-1:0] conv_b;
   } sample_pair_type;
endpackage

/* include/adc_seq_regs.svh */
// timing counts, field widths and reset values for the conversion
// sequencer; included by the package user, holds definitions only
`ifndef ADC_SEQ_REGS_SVH
`define ADC_SEQ_REGS_SVH

// clock period of the system clock in picoseconds
`define SYS_PERIOD_PS 8000
// conversion length in external clock periods
`define CONV_PERIODS 13
// busy falls after this rising edge, counted from the start edge
`define BUSY_END_EDGE 14
// sample width of each converter
`define SAMPLE_BITS 12
// reference dac code width and power-up value
`define REF_DAC_BITS 10
`define REF_DAC_RESET 10'h3ff
// channel code reset value
`define INPUT_CODE_RESET 2'h0
// fifo depth in words
`define FIFO_DEPTH 32

`endif

/* test/host_model.sv */
// host controller model: trigger, conversion clock and parallel strobes
// assumes the bench calls its tasks and that one clock paces everything
`timescale 1ns/1ps
module host_model (
   // clock
   input wire logic clk_sys_in,
   // to the sequencer
   output logic trigger_n_out,
   output logic ext_clock_out,
   output logic select_n_out,
   output logic read_n_out,
   output logic write_n_out,
   output logic [11:0] write_data_out,
   output logic write_is_dac_out,
   // from the sequencer
   input wire logic read_valid_in,
   input wire logic [11:0] read_data_in
);
   logic run; // conversion clock enable
   logic [1:0] div; // divider, clock is sys/4
   // ------------------------------------------------------------
   // conversion clock
   // ------------------------------------------------------------
   initial begin
      {trigger_n_out, select_n_out, read_n_out, write_n_out} = 4'hf;
      {ext_clock_out, run, div, write_is_dac_out} = 5'h0;
      write_data_out = 12'h000;
   end
   // clock runs through the whole conversion, low between frames
   always @(negedge clk_sys_in) begin
      div <= run ? div + 2'h1 : 2'h0;
      // 0,1,1,0 over four cycles keeps the duty cycle at one half
      ext_clock_out <= run & (div[1] ^ div[0]);
   end
   // ------------------------------------------------------------
   // strobe tasks
   // ------------------------------------------------------------
   // with go set trigger falls and the clock starts, else trigger rises and the clock stops; only issued while idle
   // twelve idle cycles before a fall leave acquisition time
   task automatic start(input logic go);
      repeat (go ? 12 : 1) @(negedge clk_sys_in);
      trigger_n_out = ~go; // rises only off clock edges
      // non-blocking, so the divider sees the old enable this edge
      run <= go;
   endtask
   // write with select low when sel is set, high otherwise; rising strobe latches the data
   task automatic wr(input logic sel, input logic dac, input logic [11:0] d);
      @(negedge clk_sys_in);
      {select_n_out, write_is_dac_out, write_data_out} = {~sel, dac, d};
      write_n_out = 1'b0;
      @(negedge clk_sys_in);
      write_n_out = 1'b1;
      @(negedge clk_sys_in);
      select_n_out = 1'b1;
      write_data_out = ~d; // released bus shows no stale value
   endtask
   // read well before the next busy rise
   task automatic rd(input logic sel, output logic v, output logic [11:0] d);
      @(negedge clk_sys_in);
      select_n_out = ~sel;
      read_n_out = 1'b0;
      // valid pulse is launched by the next rising edge, taken mid-cycle
      @(negedge clk_sys_in);
      v = read_valid_in;
      d = read_data_in;
      {select_n_out, read_n_out} = 2'h3;
   endtask
endmodule

/* test/tb_dual_adc_conversion_sequencer.sv */
// self-checking bench for the conversion sequencer
// assumes the host model paces all strobes off the falling clock edge
`timescale 1ns/1ps
module tb_dual_adc_conversion_sequencer;
   import adc_seq_pkg::*;
   typedef struct packed {
      logic pseudo;
      logic [1:0] code;
      logic [5:0] route;
   } row_type;
   logic clk_sys_in, rst_in, nap, pseudo, sel_n, rd_n, wr_n, dac, trg, ext;
   logic busy, hold, rv, ovf, v, prev;
   logic [11:0] wd, rdat, d;
   logic [3:0] step;
   logic [9:0] refo;
   logic [1:0] code;
   mux_route_type route;
   int bad_count, n_checks, rises;
   row_type rows [7];
   dual_adc_conversion_sequencer u_dual_adc_conversion_sequencer (
      .clk_sys_in(clk_sys_in), .rst_in(rst_in),
      .sample_hold_trigger_n_in(trg), .ext_clock_in(ext),
      .auto_nap_in(nap), .select_n_in(sel_n), .read_n_in(rd_n),
      .write_n_in(wr_n), .write_data_in(wd), .write_is_dac_in(dac),
      .conv_a_result_in(12'h5a3), .conv_b_result_in(12'ha5c),
      .pseudo_mode_in(pseudo), .busy_out(busy), .hold_out(hold),
      .conv_step_out(step), .route_out(route),
      .reference_output_out(refo), .input_code_out(code),
      .read_data_out(rdat), .read_valid_out(rv), .overflow_out(ovf));
   host_model u_host_model (
      .clk_sys_in(clk_sys_in), .trigger_n_out(trg), .ext_clock_out(ext),
      .select_n_out(sel_n), .read_n_out(rd_n), .write_n_out(wr_n),
      .write_data_out(wd), .write_is_dac_out(dac),
      .read_valid_in(rv), .read_data_in(rdat));
   // ------------------------------------------------------------
   // clock and reporting
   // ------------------------------------------------------------
   initial begin
      clk_sys_in = 1'b0;
      forever #4 clk_sys_in = ~clk_sys_in;
   end
   task automatic chk(input logic [11:0] got, input logic [11:0] exp);
      n_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic final_report;
      $display("checks=%0d mismatches=%0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // one conversion; counts clock rises seen while busy is high
   task automatic convert;
      u_host_model.start(1'b1);
      @(posedge clk_sys_in);
      @(posedge clk_sys_in);
      #1 chk({11'h0, busy}, {11'h0, ~nap}); // busy one cycle on
      chk({11'h0, hold}, 12'h001); // both converters hold
      rises = 0;
      prev = ext;
      for (int i = 0; i < 200 && (busy || nap && i < 80); i++) begin
         @(posedge clk_sys_in);
         #1 rises += int'(ext & ~prev & busy);
         prev = ext;
      end
      if (busy) chk(12'hbad, 12'h000); // conversion never ended
      chk({8'h0, step}, 12'h00e); // last counted edge
      chk({11'h0, hold}, 12'h000); // hold released
      u_host_model.start(1'b0);
   endtask
   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      bad_count = 0;
      n_checks = 0;
      nap = 1'b0;
      pseudo = 1'b0;
      rst_in = 1'b1;
      repeat (5) @(posedge clk_sys_in);
      @(negedge clk_sys_in);
      rst_in = 1'b0;
      chk({2'h0, refo}, 12'h3ff); // dac resets to full scale
      chk({10'h0, code}, 12'h000);
      chk({11'h0, busy}, 12'h000);
      // routing table: differential and pseudo-differential codes
      rows = '{'{0, 0, 6'o12}, '{0, 3, 6'o34}, '{0, 1, 6'o00},
               '{1, 0, 6'o12}, '{1, 1, 6'o42}, '{1, 2, 6'o32},
               '{1, 3, 6'o00}};
      foreach (rows[i]) begin
         pseudo = rows[i].pseudo;
         u_host_model.wr(1'b1, 1'b0, {10'h0, rows[i].code});
         chk({6'h0, route}, {6'h0, rows[i].route});
      end
      // writes with select high are ignored
      u_host_model.wr(1'b0, 1'b1, 12'h0cd);
      chk({2'h0, refo}, 12'h3ff);
      u_host_model.wr(1'b1, 1'b1, 12'h1fd);
      chk({2'h0, refo}, 12'h1fd);
      // conversion spans the fourteenth clock rise
      convert();
      chk(12'(rises), 12'd14);
      // reads: select high refused, then a and b of one pair
      u_host_model.rd(1'b0, v, d);
      chk({11'h0, v}, 12'h000);
      u_host_model.rd(1'b1, v, d);
      chk(d, 12'h5a3);
      chk({11'h0, v}, 12'h001);
      u_host_model.rd(1'b1, v, d);
      chk(d, 12'ha5c);
      u_host_model.rd(1'b1, v, d);
      chk({11'h0, v}, 12'h000); // fifo empty
      // back-to-back conversion in nap mode: busy stays low
      nap = 1'b1;
      convert();
      chk({11'h0, busy}, 12'h000);
      // fill the fifo and its holding slot; the next pair is dropped
      for (int k = 0; k < 33; k++) begin
         convert();
      end
      chk({11'h0, ovf}, 12'h001);
      // reset in mid-run clears the fifo and the flag and returns the dac to full scale
      @(negedge clk_sys_in);
      rst_in = 1'b1;
      repeat (2) @(negedge clk_sys_in);
      rst_in = 1'b0;
      chk({11'h0, ovf}, 12'h000);
      chk({2'h0, refo}, 12'h3ff);
      u_host_model.rd(1'b1, v, d);
      chk({11'h0, v}, 12'h000);
      final_report();
   end
endmodule
